// [core/hps_status.sv]
// Hub port status register with per-port reset, enable and suspend state.
// Assumes SFR reads on the device clock, an EOF2 pulse from the frame timer,
// port control pulses decoded from the port control register outside,
// and the port select value held by the port select register outside.
//
// How it works
// - Read-only byte at D7, resets to 04.
// - Bit 3 shows reset signalling on port.
// - Control-register reset request starts reset signalling.
// - Reset, suspend, enable change only at EOF2.
// - Bit 2 shows port suspended.
// - Bit 1 shows port enabled.
// - Embedded port shares reset, suspend, enable behaviour.
// - Bit 0 is connect state from EOF2.
// - Connect set on attach; hub reset clears it.
// - Connect cleared when disconnect detected.
// - Embedded port connect bit one from the first EOF2 on; reset gives zero.
// - No per-port overcurrent bit; power ganged.
// - Port changes wait for downstream signalling time.
// - Hardware starts some changes, flags them.
// - Bits 7,6 line levels; embedded fixed 1,0.
// - Bit 5 low speed; embedded fixed zero.
// - Bit 4 power state; embedded fixed one.
// - Port select picks which port shows.
`timescale 1ns/1ps
`include "hps_defs.svh"
module hps_status
	import hps_pkg::*;
#(
	parameter logic [`HPS_TIMER_W-1:0] RST_CYCLES = `HPS_TIMER_W'(`HPS_RST_CYCLES)
) (
	// Clock and reset
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_n_in,
	// SFR read port
	input  wire logic [7:0]                sfr_addr_in,
	input  wire logic                      sfr_rd_in,
	output logic [7:0]                     sfr_rdata_out,
	output logic                           sfr_rd_hit_out,
	// Port select from the select register
	input  wire logic [1:0]                hub_port_select_in,
	// Frame timing
	input  wire logic                      eof2_in,
	// Port control pulses and levels
	input  wire logic [`HPS_NPORTS-1:0]    port_reset_req_in,
	input  wire logic [`HPS_NPORTS-1:0]    port_enable_req_in,
	input  wire logic [`HPS_NPORTS-1:0]    port_disable_req_in,
	input  wire logic [`HPS_NPORTS-1:0]    port_suspend_ctl_in,
	input  wire logic [`HPS_NEXT-1:0]      hub_port_power_control_in,
	// Downstream pins of the external ports
	input  wire logic [`HPS_NEXT-1:0]      plus_line_level_in,
	input  wire logic [`HPS_NEXT-1:0]      minus_line_level_in,
	input  wire logic [`HPS_NEXT-1:0]      low_speed_attached_in,
	input  wire logic [`HPS_NEXT-1:0]      attach_detect_in,
	input  wire logic                      overcurrent_in,
	// Port drive and change events
	output logic [`HPS_NPORTS-1:0]         port_reset_drive_out,
	output logic [`HPS_NPORTS-1:0]         port_change_out
);
	hps_state_t q;
	hps_state_t d;

	logic [7:0]               snap [`HPS_NPORTS];
	logic [`HPS_NPORTS-1:0]   live_suspended;
	logic [`HPS_NPORTS-1:0]   live_connected;
	logic [`HPS_NPORTS-1:0]   live_powered;
	logic [`HPS_NPORTS-1:0]   live_plus;
	logic [`HPS_NPORTS-1:0]   live_minus;
	logic [`HPS_NPORTS-1:0]   live_low_speed;

	// Address decode of the status register
	function automatic logic status_hit(input logic [7:0] addr);
		status_hit = (addr == `HPS_STATUS_ADDR);
	endfunction

	// Status byte of the selected port
	function automatic logic [7:0] pick_port(
		input logic [7:0] s0,
		input logic [7:0] s1,
		input logic [7:0] s2,
		input logic [7:0] s3,
		input logic [1:0] sel
	);
		case (sel)
			2'h0: pick_port = s0;
			2'h1: pick_port = s1;
			2'h2: pick_port = s2;
			default: pick_port = s3;
		endcase
	endfunction

	// Live values feeding the snapshots
	always_comb begin
		live_suspended = port_suspend_ctl_in & q.en;
		live_connected = {1'b1, q.sync2[`HPS_SYNC_CONN +: `HPS_NEXT]};
		// Power removed by the ganged overcurrent input
		live_powered   = {1'b1, hub_port_power_control_in
			& {`HPS_NEXT{~q.sync2[`HPS_SYNC_OC]}}};
		live_plus      = {1'b1, q.sync2[`HPS_SYNC_PLUS +: `HPS_NEXT]};
		live_minus     = {1'b0, q.sync2[`HPS_SYNC_MINUS +: `HPS_NEXT]};
		live_low_speed = {1'b0, q.sync2[`HPS_SYNC_LOWSPD +: `HPS_NEXT]};
	end

	// Next state
	always_comb begin
		d = q;

		// Two-stage synchroniser for the downstream pins
		d.sync1 = {overcurrent_in,
			attach_detect_in,
			low_speed_attached_in,
			minus_line_level_in,
			plus_line_level_in};
		d.sync2 = q.sync1;
		d.conn_prev = q.sync2[`HPS_SYNC_CONN +: `HPS_NEXT];
		d.oc_prev = q.sync2[`HPS_SYNC_OC];

		d.change = '0;

		for (int i = 0; i < `HPS_NPORTS; i++) begin
			case (q.pst[i])
				HPS_PS_IDLE: begin
					if (port_reset_req_in[i]) begin
						// Reset signalling runs for the full downstream time
						d.pst[i] = HPS_PS_RESET;
						d.timer[i] = RST_CYCLES - `HPS_TIMER_W'(1);
						d.rst_drive[i] = 1'b1;
						d.en[i] = 1'b0;
					end else if (port_disable_req_in[i]) begin
						d.en[i] = 1'b0;
					end else if (port_enable_req_in[i] && live_connected[i]) begin
						d.en[i] = 1'b1;
					end
				end
				HPS_PS_RESET: begin
					if (q.timer[i] == '0) begin
						d.pst[i] = HPS_PS_DONE;
						d.rst_drive[i] = 1'b0;
					end else begin
						d.timer[i] = q.timer[i] - `HPS_TIMER_W'(1);
					end
				end
				HPS_PS_DONE: begin
					// Reset completion enables the port and flags a change
					d.pst[i] = HPS_PS_IDLE;
					d.en[i] = 1'b1;
					d.change[i] = 1'b1;
				end
				default: begin
					d.pst[i] = HPS_PS_IDLE;
					d.rst_drive[i] = 1'b0;
					d.timer[i] = '0;
				end
			endcase
		end

		// Hardware-initiated changes on the external ports
		for (int i = 0; i < `HPS_NEXT; i++) begin
			if (q.conn_prev[i] && !q.sync2[`HPS_SYNC_CONN + i]) begin
				// Disconnect disables the port
				d.en[i] = 1'b0;
				d.change[i] = 1'b1;
			end
			if (!q.conn_prev[i] && q.sync2[`HPS_SYNC_CONN + i]) begin
				d.change[i] = 1'b1;
			end
			if (!q.oc_prev && q.sync2[`HPS_SYNC_OC]) begin
				d.change[i] = 1'b1;
			end
		end

		// Register read
		d.rd_hit = sfr_rd_in && status_hit(sfr_addr_in);
		if (d.rd_hit) begin
			d.rdata = pick_port(snap[0], snap[1], snap[2], snap[3],
				hub_port_select_in);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			q.sync1 <= '0;
			q.sync2 <= '0;
			q.conn_prev <= '0;
			q.oc_prev <= 1'b0;
			q.pst <= {`HPS_NPORTS{HPS_PS_IDLE}};
			q.timer <= '0;
			q.en <= '0;
			q.rst_drive <= '0;
			q.change <= '0;
			q.rdata <= `HPS_STATUS_RST;
			q.rd_hit <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// Snapshots at EOF2, one per port
	for (genvar p = 0; p < `HPS_NPORTS; p++) begin : g_port
		hps_port_sampler #(
			.EMBEDDED (p == `HPS_NPORTS - 1)
		) u_sampler (
			.ref_clk_in   (ref_clk_in),
			.rst_n_in     (rst_n_in),
			.eof2_in      (eof2_in),
			.plus_in      (live_plus[p]),
			.minus_in     (live_minus[p]),
			.low_speed_in (live_low_speed[p]),
			.powered_in   (live_powered[p]),
			.in_reset_in  (q.rst_drive[p]),
			.suspended_in (live_suspended[p]),
			.enabled_in   (q.en[p]),
			.connected_in (live_connected[p]),
			.status_out   (snap[p])
		);
	end

	assign sfr_rdata_out        = q.rdata;
	assign sfr_rd_hit_out       = q.rd_hit;
	assign port_reset_drive_out = q.rst_drive;
	assign port_change_out      = q.change;
endmodule

// [core/hps_defs.svh]
// Constants of the hub port status register: address, reset value,
// bit positions, pin map of the synchroniser and reset timing.
// Assumes the 25 MHz device clock.
`ifndef HPS_DEFS_SVH
`define HPS_DEFS_SVH

// Register address and reset value
`define HPS_STATUS_ADDR   8'hd7
`define HPS_STATUS_RST    8'h04

// Status bit positions
`define HPS_BIT_PLUS      7
`define HPS_BIT_MINUS     6
`define HPS_BIT_LOWSPD    5
`define HPS_BIT_POWER     4
`define HPS_BIT_RESET     3
`define HPS_BIT_SUSPEND   2
`define HPS_BIT_ENABLE    1
`define HPS_BIT_CONNECT   0

// Port counts
`define HPS_NPORTS        4
`define HPS_NEXT          3

// Synchroniser bit map of the pin inputs
`define HPS_SYNC_W        13
`define HPS_SYNC_PLUS     0
`define HPS_SYNC_MINUS    3
`define HPS_SYNC_LOWSPD   6
`define HPS_SYNC_CONN     9
`define HPS_SYNC_OC       12

// Reset signalling time on a port
`define HPS_CLK_KHZ       25000
`define HPS_RST_TIME_MS   20
`define HPS_RST_CYCLES    (`HPS_RST_TIME_MS * `HPS_CLK_KHZ)
`define HPS_TIMER_W       20

`endif

// [core/hps_pkg.sv]
// Types shared by the hub port status block.
// Assumes hps_defs.svh is on the include path.
package hps_pkg;
	`include "hps_defs.svh"

	typedef enum logic [2:0] {
		HPS_PS_IDLE  = 3'b001,
		HPS_PS_RESET = 3'b010,
		HPS_PS_DONE  = 3'b100
	} hps_pstate_t;

	typedef struct packed {
		logic [7:0] snap;
	} hps_snap_t;

	typedef struct packed {
		logic [`HPS_SYNC_W-1:0]                          sync1;
		logic [`HPS_SYNC_W-1:0]                          sync2;
		logic [`HPS_NEXT-1:0]                            conn_prev;
		logic                                            oc_prev;
		hps_pstate_t [`HPS_NPORTS-1:0]                   pst;
		logic [`HPS_NPORTS-1:0][`HPS_TIMER_W-1:0]        timer;
		logic [`HPS_NPORTS-1:0]                          en;
		logic [`HPS_NPORTS-1:0]                          rst_drive;
		logic [`HPS_NPORTS-1:0]                          change;
		logic [7:0]                                      rdata;
		logic                                            rd_hit;
	} hps_state_t;
endpackage

// [core/hps_port_sampler.sv]
// Per-port snapshot of the status byte, taken at each EOF2 point.
// Assumes live inputs on the device clock and a one-cycle EOF2 pulse.
`timescale 1ns/1ps
`include "hps_defs.svh"
module hps_port_sampler
	import hps_pkg::*;
#(
	parameter bit EMBEDDED = 1'b0
) (
	// Clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	// Frame timing
	input  wire logic       eof2_in,
	// Live port state
	input  wire logic       plus_in,
	input  wire logic       minus_in,
	input  wire logic       low_speed_in,
	input  wire logic       powered_in,
	input  wire logic       in_reset_in,
	input  wire logic       suspended_in,
	input  wire logic       enabled_in,
	input  wire logic       connected_in,
	// Snapshot
	output logic [7:0]      status_out
);
	hps_snap_t q;
	hps_snap_t d;

	always_comb begin
		d = q;
		if (eof2_in) begin
			// Embedded port has fixed line, speed, power and connect bits
			d.snap[`HPS_BIT_PLUS]    = EMBEDDED ? 1'b1 : plus_in;
			d.snap[`HPS_BIT_MINUS]   = EMBEDDED ? 1'b0 : minus_in;
			d.snap[`HPS_BIT_LOWSPD]  = EMBEDDED ? 1'b0 : low_speed_in;
			d.snap[`HPS_BIT_POWER]   = EMBEDDED ? 1'b1 : powered_in;
			d.snap[`HPS_BIT_RESET]   = in_reset_in;
			d.snap[`HPS_BIT_SUSPEND] = suspended_in;
			d.snap[`HPS_BIT_ENABLE]  = enabled_in;
			d.snap[`HPS_BIT_CONNECT] = EMBEDDED ? 1'b1 : connected_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			q <= '{snap: `HPS_STATUS_RST};
		end else begin
			q <= d;
		end
	end

	assign status_out = q.snap;
endmodule

// [tb/hps_status_props.sv]
// Port checker of the hub port status block.
// Assumes the bind below and a shortened reset count.
`timescale 1ns/1ps
module hps_status_props
	import hps_pkg::*;
#(
	parameter int RST_CYCLES = 8
) (
	// Watched ports
	input wire logic       ref_clk_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic       sfr_rd_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic       sfr_rd_hit_out,
	input wire logic [1:0] hub_port_select_in,
	input wire logic       eof2_in,
	input wire logic [3:0] port_reset_req_in,
	input wire logic [3:0] port_reset_drive_out,
	input wire logic [3:0] port_change_out
);
	localparam int RCM = RST_CYCLES - 1;
	logic seen_q;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Set once a snapshot has been taken since reset
	always_ff @(posedge ref_clk_in) begin
		seen_q <= rst_n_in & (seen_q | eof2_in);
	end
	property p_rd_hit; sfr_rd_in && sfr_addr_in == 8'hd7 |=> sfr_rd_hit_out; endproperty
	a_rd_hit: assert property (p_rd_hit) else $error("no hit");
	property p_rd_hold; !sfr_rd_hit_out |-> $stable(sfr_rdata_out); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("data moved");
	property p_rst_val;
		$rose(rst_n_in) |-> sfr_rdata_out == 8'h04 && !sfr_rd_hit_out
			&& port_reset_drive_out == 4'h0 && port_change_out == 4'h0;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("bad reset");
	property p_same_frame;
		sfr_rd_hit_out && $past(sfr_rd_hit_out) && !$past(eof2_in, 2)
			&& $past(hub_port_select_in, 2) == $past(hub_port_select_in)
			|-> $stable(sfr_rdata_out);
	endproperty
	a_same_frame: assert property (p_same_frame) else $error("moved in frame");
	property p_emb_fixed;
		sfr_rd_hit_out && $past(hub_port_select_in) == 2'h3 && $past(seen_q)
			|-> (sfr_rdata_out & 8'hf1) == 8'h91;
	endproperty
	a_emb_fixed: assert property (p_emb_fixed) else $error("bad fixed bits");
	property p_rst_start; $rose(port_reset_drive_out[0]) |-> $past(port_reset_req_in[0]); endproperty
	a_rst_start: assert property (p_rst_start) else $error("drive uncaused");
	property p_rst_len;
		$rose(port_reset_drive_out[0])
			|-> (port_reset_drive_out[0] throughout ##RCM 1'b1) ##1 !port_reset_drive_out[0];
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("drive length");
	property p_rst_done; $fell(port_reset_drive_out[3]) |=> port_change_out[3]; endproperty
	a_rst_done: assert property (p_rst_done) else $error("no change");
	c_emb: cover property (sfr_rd_hit_out && $past(hub_port_select_in) == 2'h3);
	c_done: cover property ($fell(port_reset_drive_out[3]));
	c_chg: cover property (port_change_out[0]);
endmodule
bind hps_status hps_status_props #(.RST_CYCLES(RST_CYCLES)) u_props (
	.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in),
	.sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .sfr_rd_hit_out(sfr_rd_hit_out),
	.hub_port_select_in(hub_port_select_in), .eof2_in(eof2_in),
	.port_reset_req_in(port_reset_req_in), .port_reset_drive_out(port_reset_drive_out),
	.port_change_out(port_change_out));

// [tb/hps_dev_model.sv]
// Devices on the three external downstream ports.
// Assumes pull-downs on both lines of every port.
`timescale 1ns/1ps
module hps_dev_model (
	// Device choice
	input  wire logic [2:0] attach_in,
	input  wire logic [2:0] slow_in,
	// Port pins
	output logic [2:0]      plus_out,
	output logic [2:0]      minus_out,
	output logic [2:0]      low_speed_out,
	output logic [2:0]      attach_out
);
	// Idle state per speed; both lines low with nothing attached
	assign plus_out = attach_in & ~slow_in;
	assign minus_out = attach_in & slow_in;
	assign low_speed_out = attach_in & slow_in;
	assign attach_out = attach_in;
endmodule

// [tb/hps_status_tb.sv]
// Self-checking bench of the hub port status block.
// Assumes the checker bind and the device model.
`timescale 1ns/1ps
module hps_status_tb;
	import hps_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        rd = 1'b0;
	logic        eof2 = 1'b0;
	logic        oc = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [1:0]  sel = 2'h0;
	logic [3:0]  rreq, enq, dis, susp, en, rs, drv, chg;
	logic [2:0]  pwr, att, slow, dp, dm, ls, ad;
	logic [7:0]  rdata;
	logic        hit;
	logic [7:0]  snap [4] = '{default: 8'h04};
	logic [7:0]  exp_q [$];
	logic [31:0] lf = 32'hf9fa;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          n_done = 0;
	always #20 clk = ~clk;
	hps_dev_model u_dev (.attach_in(att), .slow_in(slow), .plus_out(dp), .minus_out(dm),
		.low_speed_out(ls), .attach_out(ad));
	hps_status #(.RST_CYCLES(20'h8)) DUT (.ref_clk_in(clk), .rst_n_in(rst_n),
		.sfr_addr_in(addr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .sfr_rd_hit_out(hit),
		.hub_port_select_in(sel), .eof2_in(eof2), .port_reset_req_in(rreq),
		.port_enable_req_in(enq), .port_disable_req_in(dis), .port_suspend_ctl_in(susp),
		.hub_port_power_control_in(pwr), .plus_line_level_in(dp), .minus_line_level_in(dm),
		.low_speed_attached_in(ls), .attach_detect_in(ad), .overcurrent_in(oc),
		.port_reset_drive_out(drv), .port_change_out(chg));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [7:0] exp_byte(input int p);
		if (p == 3) return {4'h9, rs[3], susp[3] & en[3], en[3], 1'b1};
		return {dp[p], dm[p], ls[p], pwr[p] & ~oc, rs[p], susp[p] & en[p], en[p], ad[p]};
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Optional snapshot, then back-to-back reads and one unmapped read
	task automatic frame(input bit ef, input int id);
		int p;
		step(4);
		if (ef) begin
			for (int i = 0; i < 4; i++) snap[i] = exp_byte(i);
			eof2 = 1'b1;
			step(1);
			eof2 = 1'b0;
		end
		addr = 8'hd7;
		rd = 1'b1;
		for (int i = 0; i < 5; i++) begin
			p = (i == 0) ? 0 : i - 1;
			sel = p[1:0];
			exp_q.push_back(snap[p]);
			step(1);
		end
		addr = 8'hd6;
		step(1);
		rd = 1'b0;
		step(2);
		$display("frame test %0d done", id);
	endtask
	task automatic tally_and_finish();
		bad_count += exp_q.size();
		$display("compared %0d mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		if (chg[3] === 1'b1) n_done++;
		if (hit === 1'b1) begin
			samples_checked++;
			if (exp_q.size() == 0 || rdata !== exp_q[0]) begin
				bad_count++;
				$display("unexpected at %0t: got %h want %h", $time, rdata, exp_q[0]);
			end
			if (exp_q.size() > 0) exp_q.delete(0);
		end
	end
	initial begin
		{rreq, enq, dis, susp, en, rs, pwr, att, slow} = '0;
		step(16);
		rst_n = 1'b1;
		frame(1'b0, 0);
		for (int k = 1; k < 4; k++) begin
			lf = lfsr(lf);
			{susp, pwr, slow, att} = lf[12:0] | 13'h1;
			step(4);
			enq = 4'hf;
			dis = {2'b00, lf[13], 1'b0};
			en = {1'b1, att} & ~dis;
			step(1);
			{enq, dis} = '0;
			frame(1'b1, k);
			susp = ~susp;
			dis = 4'hf;
			en = 4'h0;
			step(1);
			dis = 4'h0;
			frame(1'b0, k);
		end
		rreq = 4'h9;
		step(1);
		rreq = 4'h0;
		samples_checked++;
		if (drv !== 4'h9) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, drv, 4'h9);
		end
		rs = 4'h9;
		frame(1'b1, 4);
		samples_checked++;
		if (drv !== 4'h0) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, drv, 4'h0);
		end
		for (int i = 0; i < 50 && n_done == 0; i++) step(1);
		if (n_done == 0) bad_count++;
		rs = 4'h0;
		en = 4'h9;
		frame(1'b1, 5);
		att = 3'h0;
		oc = 1'b1;
		en = 4'h8;
		frame(1'b1, 6);
		tally_and_finish();
	end
endmodule
